// *** design/csf4_filter.sv ***
// Current setpoint filter four: registers, sample path and second-order section
// Contract
// - Type 1 low pass, 2 general; reset 1
// - Filter only while enable word bit 3 set
// - Denominator frequency 0.5 to 16000 Hz, reset 1999
// - Denominator damping 0.001 to 10, reset 0.7
// - Numerator frequency 0.5 to 16000, general only
// - Numerator damping 0 to 10, reset 0.7
// - Settings change while running, no stop
// - Equal frequencies notch; zero damping fully suppresses
// - Notch 3 dB bandwidth is 2*damping*frequency
`timescale 1ns/1ps
module csf4_filter
  import csf4_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter int SAMPLE_HZ = 64000,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic sp_valid_i,
  input wire logic [DATA_W-1:0] sp_data_i,
  output logic sp_ready_o,
  output logic out_valid_o,
  output logic [DATA_W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam logic signed [31:0] D_HI = (32'sh0000_0001 <<< (DATA_W - 1)) - 32'sh0000_0001;
  localparam logic signed [31:0] D_LO = -D_HI - 32'sh0000_0001;

  logic [15:0] filter_four_type;
  logic [31:0] filter_four_den_frequency;
  logic [31:0] filter_four_den_damping;
  logic [31:0] filter_four_num_frequency;
  logic [31:0] filter_four_num_damping;
  logic [15:0] setpoint_filter_enable_word;
  logic [15:0] sample_count;
  logic param_wr;
  logic coef_pending;
  logic coef_start;
  logic coef_busy;
  logic coef_valid;
  csf4_coef_t coef_g;
  csf4_coef_t coef_cd;
  csf4_coef_t coef_cu;
  csf4_coef_t coef_cb;
  csf4_coef_t coef_cy;
  logic fifo_valid;
  logic [DATA_W-1:0] fifo_data;
  logic fifo_ready;
  logic take;
  logic active;
  csf4_coef_t state_b;
  csf4_coef_t state_y;
  csf4_coef_t u_ext;
  csf4_coef_t err;
  csf4_coef_t next_b;
  csf4_coef_t next_y;
  logic signed [63:0] acc;
  logic [DATA_W-1:0] next_out;

  function automatic logic [DATA_W-1:0] sat_data(input logic signed [31:0] v);
    if (v > D_HI) return D_HI[DATA_W-1:0];
    if (v < D_LO) return D_LO[DATA_W-1:0];
    return v[DATA_W-1:0];
  endfunction

  csf4_fifo #(
    .W(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .in_valid_i(sp_valid_i),
    .in_data_i(sp_data_i),
    .in_ready_o(sp_ready_o),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(fifo_ready)
  );

  csf4_coef #(
    .SAMPLE_HZ(SAMPLE_HZ)
  ) u_coef (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .start_i(coef_start),
    .type_i(filter_four_type),
    .den_freq_i(filter_four_den_frequency),
    .den_damp_i(filter_four_den_damping),
    .num_freq_i(filter_four_num_frequency),
    .num_damp_i(filter_four_num_damping),
    .busy_o(coef_busy),
    .valid_o(coef_valid),
    .g_o(coef_g),
    .cd_o(coef_cd),
    .cu_o(coef_cu),
    .cb_o(coef_cb),
    .cy_o(coef_cy)
  );

  assign active = setpoint_filter_enable_word[ENABLE_BIT];
  assign param_wr = wr_i && (addr_i inside {OFF_TYPE, OFF_DEN_FREQ, OFF_DEN_DAMP,
                                            OFF_NUM_FREQ, OFF_NUM_DAMP});
  assign coef_start = coef_pending && !coef_busy;
  // No samples until the first coefficient set exists after reset
  assign fifo_ready = (!out_valid_o || out_ready_i) && coef_valid;
  assign take = ce_i && fifo_valid && fifo_ready;

  // Illegal type codes are ignored and the old type stays
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      filter_four_type <= TYPE_LOWPASS;
    end else if (ce_i && wr_i && addr_i == OFF_TYPE) begin
      if (wdata_i[15:0] == TYPE_LOWPASS || wdata_i[15:0] == TYPE_GENERAL) begin
        filter_four_type <= wdata_i[15:0];
      end
    end
  end

  // Out-of-range writes are clamped, not refused
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      filter_four_den_frequency <= FREQ_RST;
      filter_four_den_damping <= DAMP_RST;
      filter_four_num_frequency <= FREQ_RST;
      filter_four_num_damping <= DAMP_RST;
    end else if (ce_i && wr_i) begin
      case (addr_i)
        OFF_DEN_FREQ: filter_four_den_frequency <= csf4_clamp(wdata_i, FREQ_MIN, FREQ_MAX);
        OFF_DEN_DAMP: filter_four_den_damping <= csf4_clamp(wdata_i, DEN_DAMP_MIN, DAMP_MAX);
        OFF_NUM_FREQ: filter_four_num_frequency <= csf4_clamp(wdata_i, FREQ_MIN, FREQ_MAX);
        OFF_NUM_DAMP: filter_four_num_damping <= csf4_clamp(wdata_i, NUM_DAMP_MIN, DAMP_MAX);
        default: filter_four_den_frequency <= filter_four_den_frequency;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      setpoint_filter_enable_word <= ENABLE_RST;
    end else if (ce_i && wr_i && addr_i == OFF_ENABLE) begin
      setpoint_filter_enable_word <= wdata_i[15:0];
    end
  end

  // A write landing during a pass re-arms the request, so it is never lost
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      coef_pending <= 1'b1;
    end else if (ce_i) begin
      coef_pending <= param_wr || (coef_pending && !coef_start);
    end
  end

  // Semi-implicit state-variable section; b is band, y is low-pass state
  always_comb begin
    u_ext = 32'(signed'(fifo_data)) <<< DATA_FRAC;
    err = csf4_sat(64'(u_ext) - 64'(state_y) - 64'(csf4_mulq(coef_cd, state_b)));
    next_b = csf4_sat(64'(state_b) + 64'(csf4_mulq(coef_g, err)));
    next_y = csf4_sat(64'(state_y) + 64'(csf4_mulq(coef_g, next_b)));
    acc = 64'(csf4_mulq(coef_cu, u_ext)) + 64'(csf4_mulq(coef_cb, next_b))
        + 64'(csf4_mulq(coef_cy, next_y));
    next_out = sat_data(csf4_sat(acc) >>> DATA_FRAC);
    // Bypass keeps the states tracking the input for a bumpless switch-on
    if (!active) begin
      next_b = '0;
      next_y = u_ext;
      next_out = fifo_data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_b <= '0;
      state_y <= '0;
    end else if (take) begin
      state_b <= next_b;
      state_y <= next_y;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end else if (ce_i) begin
      if (take) begin
        out_valid_o <= 1'b1;
        out_data_o <= next_out;
      end else if (out_ready_i) begin
        out_valid_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sample_count <= '0;
    end else if (take) begin
      sample_count <= sample_count + 16'h0001;
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rdata_o <= '0;
    end else if (ce_i) begin
      rdata_o <= '0;
      if (rd_i) begin
        case (addr_i)
          OFF_TYPE: rdata_o <= {16'h0000, filter_four_type};
          OFF_DEN_FREQ: rdata_o <= filter_four_den_frequency;
          OFF_DEN_DAMP: rdata_o <= filter_four_den_damping;
          OFF_NUM_FREQ: rdata_o <= filter_four_num_frequency;
          OFF_NUM_DAMP: rdata_o <= filter_four_num_damping;
          OFF_ENABLE: rdata_o <= {16'h0000, setpoint_filter_enable_word};
          OFF_STATUS: rdata_o <= {29'h0000_0000, active, coef_busy || coef_pending, coef_valid};
          OFF_COUNT: rdata_o <= {16'h0000, sample_count};
          default: rdata_o <= '0;
        endcase
      end
    end
  end

  default clocking cb_clk @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  AST_TYPE_LEGAL: assert property (
    filter_four_type == TYPE_LOWPASS || filter_four_type == TYPE_GENERAL)
    else $error("Filter type left the legal set");
  AST_BYPASS: assert property (
    (take && !active) |=> out_valid_o && out_data_o == $past(fifo_data)
      && state_b == '0)
    else $error("Disabled stage did not pass the setpoint unchanged");
  AST_DEN_FREQ_RANGE: assert property (
    filter_four_den_frequency >= FREQ_MIN && filter_four_den_frequency <= FREQ_MAX)
    else $error("Denominator frequency out of range");
  AST_DEN_DAMP_RANGE: assert property (
    (ce_i && wr_i && addr_i == OFF_DEN_DAMP && wdata_i == NUM_DAMP_MIN)
    |=> filter_four_den_damping == DEN_DAMP_MIN)
    else $error("Denominator damping accepted zero");
  AST_NUM_FREQ_RANGE: assert property (
    (ce_i && wr_i && addr_i == OFF_NUM_FREQ && wdata_i > FREQ_MAX && !wdata_i[31])
    |=> filter_four_num_frequency == FREQ_MAX)
    else $error("Numerator frequency not clamped at the top");
  AST_NUM_DAMP_ZERO: assert property (
    (ce_i && wr_i && addr_i == OFF_NUM_DAMP && wdata_i == NUM_DAMP_MIN)
    |=> filter_four_num_damping == NUM_DAMP_MIN)
    else $error("Numerator damping refused zero");
  AST_RUN_UPDATE: assert property (
    (ce_i && param_wr && coef_valid && fifo_valid && (!out_valid_o || out_ready_i)) |-> take)
    else $error("Setting change stopped the sample path");
  AST_RECOMPUTE: assert property (
    (ce_i && param_wr) |=> (coef_pending || coef_busy) ##1 (coef_pending || coef_busy))
    else $error("Setting change did not request new coefficients");
  AST_RDATA_IDLE: assert property (
    (ce_i && !rd_i) |=> rdata_o == '0)
    else $error("Read data outside the answer cycle");
  AST_TYPE_WRITE: assert property (
    (ce_i && wr_i && addr_i == OFF_TYPE && wdata_i[15:0] == TYPE_GENERAL) |=> filter_four_type == TYPE_GENERAL)
    else $error("Legal type write did not land");
  AST_TYPE_UPPER: assert property (
    (ce_i && rd_i && addr_i == OFF_TYPE) |=> rdata_o[31:16] == 16'h0000)
    else $error("Type read shows upper bits");
  AST_ENABLE_WRITE: assert property (
    (ce_i && wr_i && addr_i == OFF_ENABLE) |=> active == $past(wdata_i[ENABLE_BIT]))
    else $error("Stage enable does not follow its bit");
  AST_DEN_FREQ_LOW: assert property (
    (ce_i && wr_i && addr_i == OFF_DEN_FREQ && (wdata_i[31] || wdata_i < FREQ_MIN))
    |=> filter_four_den_frequency == FREQ_MIN)
    else $error("Denominator frequency not clamped at the bottom");
  AST_DEN_DAMP_TOP: assert property (
    (ce_i && wr_i && addr_i == OFF_DEN_DAMP && !wdata_i[31] && wdata_i > DAMP_MAX)
    |=> filter_four_den_damping == DAMP_MAX)
    else $error("Denominator damping not clamped at the top");
  AST_NUM_FREQ_LIVE: assert property (
    filter_four_num_frequency >= FREQ_MIN && filter_four_num_frequency <= FREQ_MAX)
    else $error("Numerator frequency out of range");
  AST_NUM_DAMP_RANGE: assert property (
    filter_four_num_damping <= DAMP_MAX)
    else $error("Numerator damping out of range");
  // Clock enable low must freeze the type, the read data, the output valid and the sample count
  AST_FREEZE: assert property (
    (!ce_i) |=> $stable(filter_four_type) && $stable(rdata_o) && $stable(out_valid_o)
      && $stable(sample_count))
    else $error("State moved while the clock enable was low");

  COV_BYPASS: cover property (take && !active);
  COV_FILTERED: cover property (take && active && filter_four_type == TYPE_GENERAL);
  COV_LIVE_UPDATE: cover property (take && active && coef_busy);
  COV_STALL: cover property (out_valid_o && !out_ready_i && !sp_ready_o);
endmodule

// *** design/csf4_pkg.sv ***
// Register map, reset values and fixed-point helpers for current setpoint filter four
package csf4_pkg;
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFF_TYPE = 5'h00;
  localparam logic [4:0] OFF_DEN_FREQ = 5'h04;
  localparam logic [4:0] OFF_DEN_DAMP = 5'h08;
  localparam logic [4:0] OFF_NUM_FREQ = 5'h0C;
  localparam logic [4:0] OFF_NUM_DAMP = 5'h10;
  localparam logic [4:0] OFF_ENABLE = 5'h14;
  localparam logic [4:0] OFF_STATUS = 5'h18;
  localparam logic [4:0] OFF_COUNT = 5'h1C;
  localparam logic [15:0] TYPE_LOWPASS = 16'h0001;
  localparam logic [15:0] TYPE_GENERAL = 16'h0002;
  localparam logic [15:0] ENABLE_RST = 16'h0000;
  localparam int ENABLE_BIT = 3;
  // Single-precision bit patterns
  localparam logic [31:0] FREQ_MIN = 32'h3F00_0000;
  localparam logic [31:0] FREQ_MAX = 32'h467A_0000;
  localparam logic [31:0] FREQ_RST = 32'h44F9_E000;
  localparam logic [31:0] DEN_DAMP_MIN = 32'h3A83_126F;
  localparam logic [31:0] NUM_DAMP_MIN = 32'h0000_0000;
  localparam logic [31:0] DAMP_MAX = 32'h4120_0000;
  localparam logic [31:0] DAMP_RST = 32'h3F33_3333;
  localparam int COEF_FRAC = 24;
  localparam int FREQ_FRAC = 8;
  localparam int DATA_FRAC = 8;
  localparam int G_SHIFT = 16;
  localparam logic signed [31:0] COEF_ONE = 32'sh0100_0000;
  localparam logic signed [63:0] SAT_HI = 64'sh0000_0000_7FFF_FFFF;
  localparam logic signed [63:0] SAT_LO = 64'shFFFF_FFFF_8000_0000;

  typedef logic signed [31:0] csf4_coef_t;

  function automatic csf4_coef_t csf4_sat(input logic signed [63:0] v);
    if (v > SAT_HI) return SAT_HI[31:0];
    if (v < SAT_LO) return SAT_LO[31:0];
    return v[31:0];
  endfunction

  function automatic csf4_coef_t csf4_mulq(input csf4_coef_t a, input csf4_coef_t b);
    logic signed [63:0] p;
    p = 64'(a) * 64'(b);
    return csf4_sat(p >>> COEF_FRAC);
  endfunction

  // Positive-only values, so plain unsigned compares order them
  function automatic logic [31:0] csf4_clamp(input logic [31:0] v, input logic [31:0] lo,
                                             input logic [31:0] hi);
    if (v[31] || v < lo) return lo;
    if (v > hi) return hi;
    return v;
  endfunction

  function automatic csf4_coef_t csf4_f2fix(input logic [31:0] f, input int frac);
    int sh;
    logic [31:0] m;
    sh = int'(f[30:23]) - 150 + frac;
    m = {8'h00, 1'b1, f[22:0]};
    if (f[30:23] == 8'h00) return '0;
    if (sh > 7) return SAT_HI[31:0];
    if (sh < -23) return '0;
    if (sh >= 0) return $signed(m << sh);
    return $signed(m >> (-sh));
  endfunction
endpackage

// *** design/csf4_fifo.sv ***
// Small synchronous FIFO holding setpoint samples ahead of the filter
`timescale 1ns/1ps
module csf4_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign push = ce_i && in_valid_i && in_ready_o;
  assign pop = ce_i && out_valid_o && out_ready_i;
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // Ready is registered, so a pop frees a slot one cycle later
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready_o <= 1'b1;
    end else if (ce_i) begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= next_count;
      in_ready_o <= (next_count != (AW+1)'(DEPTH));
    end
  end
endmodule

// *** design/csf4_coef.sv ***
// Coefficient engine for the second-order section, refreshed on request
`timescale 1ns/1ps
module csf4_coef
  import csf4_pkg::*;
#(
  parameter int SAMPLE_HZ = 64000
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic [15:0] type_i,
  input wire logic [31:0] den_freq_i,
  input wire logic [31:0] den_damp_i,
  input wire logic [31:0] num_freq_i,
  input wire logic [31:0] num_damp_i,
  output logic busy_o,
  output logic valid_o,
  output csf4_coef_t g_o,
  output csf4_coef_t cd_o,
  output csf4_coef_t cu_o,
  output csf4_coef_t cb_o,
  output csf4_coef_t cy_o
);
  typedef enum logic [1:0] {C_IDLE, C_RATIO, C_MIX} csf4_cstate_e;
  localparam longint G_SCALE = longint'(6.283185307179586 * 4294967296.0 / real'(SAMPLE_HZ));
  csf4_cstate_e state;
  logic general;
  csf4_coef_t fd8;
  csf4_coef_t fn8;
  csf4_coef_t dd2;
  csf4_coef_t dn2;
  csf4_coef_t ratio;
  csf4_coef_t q;

  assign busy_o = (state != C_IDLE);
  assign q = csf4_mulq(ratio, ratio);

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state <= C_IDLE;
    end else if (ce_i) begin
      case (state)
        C_IDLE: state <= start_i ? C_RATIO : C_IDLE;
        C_RATIO: state <= C_MIX;
        C_MIX: state <= C_IDLE;
        default: state <= C_IDLE;
      endcase
    end
  end

  // Settings snapshot; later writes wait for the next pass
  always_ff @(posedge clk_i) begin
    if (ce_i && state == C_IDLE && start_i) begin
      general <= (type_i == TYPE_GENERAL);
      fd8 <= csf4_f2fix(den_freq_i, FREQ_FRAC);
      fn8 <= csf4_f2fix(num_freq_i, FREQ_FRAC);
      dd2 <= csf4_f2fix(den_damp_i, COEF_FRAC + 1);
      dn2 <= csf4_f2fix(num_damp_i, COEF_FRAC + 1);
    end
    if (ce_i && state == C_RATIO) begin
      ratio <= csf4_sat((64'(fd8) <<< COEF_FRAC) / 64'(fn8));
    end
  end

  // All coefficients switch in one edge, so a running filter never sees a mix
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      valid_o <= 1'b0;
      g_o <= '0;
      cd_o <= '0;
      cu_o <= '0;
      cb_o <= '0;
      cy_o <= '0;
    end else if (ce_i && state == C_MIX) begin
      valid_o <= 1'b1;
      g_o <= csf4_sat((64'(fd8) * G_SCALE) >>> G_SHIFT);
      cd_o <= dd2;
      if (general) begin
        cu_o <= q;
        cb_o <= csf4_sat(64'(csf4_mulq(dn2, ratio)) - 64'(csf4_mulq(dd2, q)));
        cy_o <= csf4_sat(64'(COEF_ONE) - 64'(q));
      end else begin
        cu_o <= '0;
        cb_o <= '0;
        cy_o <= COEF_ONE;
      end
    end
  end

  default clocking cb_clk @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  AST_LOWPASS_MIX: assert property (
    (ce_i && state == C_MIX && !general) |=> cu_o == '0 && cb_o == '0 && cy_o == COEF_ONE)
    else $error("Low-pass mix coefficients wrong");
  AST_NOTCH_MIX: assert property (
    (ce_i && state == C_MIX && general && fd8 == fn8)
    |=> cy_o == '0 && cu_o == COEF_ONE && cb_o == $past(dn2) - $past(dd2))
    else $error("Notch coefficients wrong for equal frequencies");
  AST_UPDATE_TIME: assert property (
    (ce_i && start_i && !busy_o) ##1 ce_i ##1 ce_i |=> valid_o && !busy_o)
    else $error("Coefficient pass did not finish in three cycles");
  COV_GENERAL_PASS: cover property (ce_i && state == C_MIX && general);
endmodule

// *** testbench/csf4_sp_source.sv ***
// Upstream setpoint source model with valid/ready handshake
`timescale 1ns/1ps
module csf4_sp_source #(
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic ce_i,
  input wire logic ready_i,
  output logic valid_o,
  output logic [W-1:0] data_o
);
  initial begin
    valid_o = 1'b0;
    data_o = '0;
  end

  // Entered just after a rising edge; returns just after the taking edge
  task automatic send(input logic [W-1:0] v, input int limit, output bit ok);
    ok = 1'b0;
    valid_o <= 1'b1;
    data_o <= v;
    for (int i = 0; i < limit && !ok; i++) begin
      @(negedge clk_i);
      // Ready is registered, so this level is what the next edge sees
      ok = (ready_i === 1'b1) && ce_i;
      @(posedge clk_i);
    end
  endtask

  // A released data line must not keep showing the last value
  task automatic idle();
    valid_o <= 1'b0;
    data_o <= ~data_o;
  endtask
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for current setpoint filter four
`timescale 1ns/1ps
module testbench
  import csf4_pkg::*;
();
  localparam int DW = 16;
  localparam logic [4:0] CA [10] = '{OFF_DEN_FREQ, OFF_DEN_FREQ, OFF_DEN_FREQ, OFF_DEN_DAMP,
    OFF_DEN_DAMP, OFF_NUM_FREQ, OFF_NUM_FREQ, OFF_NUM_DAMP, OFF_NUM_DAMP, OFF_NUM_DAMP};
  localparam logic [31:0] CW [10] = '{32'h0000_0000, 32'h4700_0000, 32'h4120_0000,
    32'h0000_0000, 32'h4130_0000, 32'hBF80_0000, 32'h7F80_0000, 32'h0000_0000,
    32'h4130_0000, 32'h3F00_0000};
  localparam logic [31:0] CE [10] = '{FREQ_MIN, FREQ_MAX, 32'h4120_0000, DEN_DAMP_MIN,
    DAMP_MAX, FREQ_MIN, FREQ_MAX, NUM_DAMP_MIN, DAMP_MAX, 32'h3F00_0000};
  logic clk_i;
  logic reset_n_i;
  logic ce_i;
  logic [ADDR_W-1:0] addr_i;
  logic [31:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [31:0] rdata_o;
  logic sp_valid_i;
  logic [DW-1:0] sp_data_i;
  logic sp_ready_o;
  logic out_valid_o;
  logic [DW-1:0] out_data_o;
  logic out_ready_i;
  int n_fail = 0;
  int samples_checked = 0;
  logic [DW-1:0] got[$];
  logic [DW-1:0] stim[$];
  logic [31:0] d;
  bit ok;

  csf4_filter #(.DATA_W(DW), .SAMPLE_HZ(64000), .FIFO_DEPTH(4)) dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sp_valid_i(sp_valid_i),
    .sp_data_i(sp_data_i), .sp_ready_o(sp_ready_o), .out_valid_o(out_valid_o),
    .out_data_o(out_data_o), .out_ready_i(out_ready_i));

  csf4_sp_source #(.W(DW)) src (.clk_i(clk_i), .ce_i(ce_i), .ready_i(sp_ready_o),
    .valid_o(sp_valid_i), .data_o(sp_data_i));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // A handshake seen at the falling edge completes at the next rising edge
  always @(negedge clk_i) begin
    if (ce_i && out_valid_o === 1'b1 && out_ready_i) got.push_back(out_data_o);
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    reg_read(a, d);
    chk(d, e);
  endtask

  task automatic run_stream();
    int n;
    n = got.size() + stim.size();
    @(posedge clk_i);
    foreach (stim[i]) begin
      src.send(stim[i], 200, ok);
      if (!ok) begin
        n_fail++;
        end_of_test();
      end
    end
    src.idle();
    for (int i = 0; i < 300 && got.size() < n; i++) @(posedge clk_i);
    if (got.size() != n) begin
      n_fail++;
      end_of_test();
    end
  endtask

  function automatic int peak(input int lo, input int hi);
    int m;
    m = 0;
    for (int i = lo; i <= hi; i++) begin
      if ($signed(got[i]) > m) m = $signed(got[i]);
      if (-$signed(got[i]) > m) m = -$signed(got[i]);
    end
    return m;
  endfunction

  initial begin
    int n;
    reset_n_i = 1'b0;
    ce_i = 1'b1;
    addr_i = '0;
    wdata_i = '0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    out_ready_i = 1'b1;
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd_chk(OFF_TYPE, 32'(TYPE_LOWPASS));
    rd_chk(OFF_DEN_FREQ, FREQ_RST);
    rd_chk(OFF_DEN_DAMP, DAMP_RST);
    rd_chk(OFF_NUM_FREQ, FREQ_RST);
    rd_chk(OFF_NUM_DAMP, DAMP_RST);
    rd_chk(OFF_ENABLE, 32'(ENABLE_RST));
    rd_chk(5'h1E, 32'h0000_0000);
    reg_read(OFF_STATUS, d);
    chk(32'(d[0]), 32'h0000_0001);
    // Illegal codes must leave the last legal type in place
    reg_write(OFF_TYPE, 32'(TYPE_GENERAL));
    rd_chk(OFF_TYPE, 32'(TYPE_GENERAL));
    reg_write(OFF_TYPE, 32'h0000_0003);
    rd_chk(OFF_TYPE, 32'(TYPE_GENERAL));
    reg_write(OFF_TYPE, 32'h0000_0000);
    rd_chk(OFF_TYPE, 32'(TYPE_GENERAL));
    reg_write(OFF_TYPE, 32'(TYPE_LOWPASS));
    rd_chk(OFF_TYPE, 32'(TYPE_LOWPASS));
    for (int i = 0; i < 10; i++) begin
      reg_write(CA[i], CW[i]);
      rd_chk(CA[i], CE[i]);
    end
    reg_write(OFF_DEN_FREQ, 32'h447A_0000);
    reg_write(OFF_NUM_FREQ, 32'h447A_0000);
    reg_write(OFF_DEN_DAMP, DAMP_RST);
    reg_write(OFF_NUM_DAMP, 32'h0000_0000);
    reg_read(OFF_STATUS, d);
    chk(32'(d[1]), 32'h0000_0001);
    // Other enable bits set, own bit clear: exact pass-through
    reg_write(OFF_ENABLE, 32'h0000_0007);
    stim = '{16'h7FFF, 16'h8000, 16'h1234, 16'hFFFF, 16'h0000};
    got.delete();
    run_stream();
    foreach (stim[i]) chk(32'(got[i]), 32'(stim[i]));
    // Downstream stalls: one sample in the output slot plus four in the FIFO
    got.delete();
    @(posedge clk_i);
    out_ready_i <= 1'b0;
    n = 0;
    for (int i = 0; i < 6; i++) begin
      src.send(16'(100 + i), 20, ok);
      if (ok) n++;
    end
    src.idle();
    chk(32'(n), 32'h0000_0005);
    @(negedge clk_i);
    chk(32'(sp_ready_o), 32'h0000_0000);
    @(posedge clk_i);
    out_ready_i <= 1'b1;
    for (int i = 0; i < 100 && got.size() < 5; i++) @(posedge clk_i);
    chk(32'(got.size()), 32'h0000_0005);
    for (int i = 0; i < 5 && i < got.size(); i++) chk(32'(got[i]), 32'(100 + i));
    @(negedge clk_i);
    chk(32'(sp_ready_o), 32'h0000_0001);
    // Zeros while bypassed leave the states at rest before the step
    stim.delete();
    repeat (8) stim.push_back(16'h0000);
    run_stream();
    reg_write(OFF_ENABLE, 32'h0000_0008);
    reg_read(OFF_STATUS, d);
    chk(d, 32'h0000_0005);
    got.delete();
    stim.delete();
    repeat (150) stim.push_back(16'd1000);
    run_stream();
    chk(32'($signed(got[0]) < 500), 32'h0000_0001);
    chk(32'($signed(got[149]) > 991 && $signed(got[149]) < 1009), 32'h0000_0001);
    // Type switched to general mid-stream: a notch at the tone frequency
    got.delete();
    stim.delete();
    for (int i = 0; i < 256; i++) stim.push_back(16'($rtoi(8000.0 * $sin(6.2831853 * i / 64.0))));
    fork
      run_stream();
      begin
        for (int k = 0; k < 3000 && got.size() < 128; k++) @(posedge clk_i);
        reg_write(OFF_TYPE, 32'(TYPE_GENERAL));
      end
    join
    chk(32'(peak(64, 127) > 4000), 32'h0000_0001);
    chk(32'(peak(192, 255) < 1000), 32'h0000_0001);
    // Every sample taken so far: 5 + 5 + 8 + 150 + 256
    reg_read(OFF_COUNT, d);
    chk(d, 32'h0000_01A8);
    // A write while the clock enable is low must be lost
    @(posedge clk_i);
    ce_i <= 1'b0;
    reg_write(OFF_TYPE, 32'(TYPE_LOWPASS));
    @(posedge clk_i);
    ce_i <= 1'b1;
    rd_chk(OFF_TYPE, 32'(TYPE_GENERAL));
    end_of_test();
  end
endmodule
